// ### dupfs_pkg.sv
// Shared constants and types for the dual serial channel pin function select block.
package dupfs_pkg;
	localparam int SYNC_STAGES = 3;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int NUM_IN = 6;
	localparam int NUM_OUT = 8;
	localparam int WR_DEPTH = 2;

	// Positions of the pins in the synchroniser vector.
	localparam int PIN_RXA = 0;
	localparam int PIN_RXB = 1;
	localparam int PIN_MI = 2;
	localparam int PIN_RST = PIN_MI + NUM_IN;
	localparam int PIN_CS = PIN_RST + 1;
	localparam int PIN_RW = PIN_CS + 1;
	localparam int PIN_ADDR = PIN_RW + 1;
	localparam int PIN_DATA = PIN_ADDR + ADDR_W;
	localparam int PIN_W = PIN_DATA + DATA_W;

	// Multipurpose input numbers with alternate functions.
	localparam int MI_CTS_A = 0;
	localparam int MI_CTS_B = 1;
	localparam int MI_RXB_CLK = 2;
	localparam int MI_TXA_CLK = 3;
	localparam int MI_RXA_CLK = 4;
	localparam int MI_TXB_CLK = 5;

	// Selector codes of the two-bit output configuration fields.
	localparam logic [1:0] OP2_GPO = 2'h0;
	localparam logic [1:0] OP2_TXA_X1 = 2'h1;
	localparam logic [1:0] OP2_TXA_X16 = 2'h2;
	localparam logic [1:0] OP2_RXA_X1 = 2'h3;
	localparam logic [1:0] OP3_GPO = 2'h0;
	localparam logic [1:0] OP3_CT = 2'h1;
	localparam logic [1:0] OP3_TXB_X1 = 2'h2;
	localparam logic [1:0] OP3_RXB_X1 = 2'h3;

	// Reset values.
	localparam logic SYNC_RST = 1'h1;
	localparam logic [NUM_OUT-1:0] MO_RST = 8'hff;
	localparam logic [NUM_OUT-1:0] MO_OE_RST = 8'hff;
	localparam logic [DATA_W-1:0] HOST_DATA_RST = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST = 4'h0;

	typedef struct packed {
		logic cts_en_a;
		logic cts_en_b;
		logic rts_en_a;
		logic rts_en_b;
		logic [1:0] op2_sel;
		logic [1:0] op3_sel;
		logic op4_alt;
		logic op5_alt;
		logic op6_alt;
		logic op7_alt;
		logic ext_rxb;
		logic ext_ct;
		logic ext_txa;
		logic ext_rxa;
		logic ext_txb;
	} dupfs_cfg_t;

	typedef struct packed {
		logic tx_bit_a;
		logic tx_bit_b;
		logic tx_en_a;
		logic tx_en_b;
		logic loop_a;
		logic loop_b;
		logic request_to_send_a_n;
		logic request_to_send_b_n;
		logic chan_a_tx_clock_x1;
		logic chan_a_tx_clock_x16;
		logic chan_a_rx_clock_x1;
		logic chan_b_tx_clock_x1;
		logic chan_b_rx_clock_x1;
		logic ct_out;
		logic chan_a_rx_flag_n;
		logic chan_b_rx_flag_n;
		logic chan_a_tx_hold_empty_n;
		logic chan_b_tx_hold_empty_n;
	} dupfs_core_t;

	typedef struct packed {
		logic serial_in_chan_a;
		logic serial_in_chan_b;
		logic clear_to_send_a_n;
		logic clear_to_send_b_n;
		logic [NUM_IN-1:0] gpi;
		logic rxb_sample;
		logic ct_clk;
		logic txa_shift;
		logic rxa_sample;
		logic txb_shift;
	} dupfs_pins_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} dupfs_wr_t;

	localparam int WR_W = $bits(dupfs_wr_t);
	localparam dupfs_pins_t PINS_RST = '{serial_in_chan_a: 1'b1, serial_in_chan_b: 1'b1,
		clear_to_send_a_n: 1'b1, clear_to_send_b_n: 1'b1, gpi: '1, default: 1'b0};

	typedef enum logic [2:0] {
		HS_IDLE,
		HS_WR_PUSH,
		HS_RD_WAIT,
		HS_RD_STB,
		HS_RD_CAP,
		HS_ACK
	} dupfs_host_state_t;
endpackage

// ### dupfs_buf.sv
// Small register buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module dupfs_buf #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 2
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic [CW-1:0] wr_idx;
	wire push = i_in_valid && o_in_ready;
	wire pop = o_out_valid && i_out_ready;

	// Entry zero is always the head, so the read side sees a flip-flop.
	assign o_out_data = mem[0];
	assign wr_idx = count - CW'(pop);
	assign next_count = count + CW'(push) - CW'(pop);

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			count <= '0;
			o_out_valid <= 1'b0;
			o_in_ready <= 1'b1;
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else begin
			count <= next_count;
			o_out_valid <= next_count != '0;
			o_in_ready <= next_count != FULL;
			for (int i = 0; i < DEPTH; i++) begin
				if (pop && i + 1 < DEPTH) begin
					mem[i] <= mem[i+1];
				end
				if (push && wr_idx == CW'(i)) begin
					mem[i] <= i_in_data;
				end
			end
		end
	end
endmodule // dupfs_buf
`default_nettype wire

// ### dupfs_top.sv
// Pin function select and host interface of a two channel serial controller.
//
// Overview of operation
// - Serial input high is one, low zero.
// - Serial output carries framed character bits.
// - Serial output held mark in reset/loop/disable.
// - Inputs 0,1 general or clear-to-send.
// - Input 2 rising edge: channel B receive/counter.
// - Inputs 3,5 falling edge shift transmit data.
// - Input 4 rising edge samples channel A.
// - Outputs 0,1 general or request-to-send.
// - Field selects output 2 function.
// - Field selects output 3 function.
// - Bit makes output 4 channel A receive flag.
// - Bit makes output 5 channel B receive flag.
// - Outputs 6,7 optional transmit empty flags.
// - Four select lines pick register, chip select gates.
// - Reset pin returns pin outputs and host state initially; buffered writes stay queued.
// - Read/write level picks read or write.
// - Acknowledge driven low per completed cycle.
`timescale 1ns/1ps
`default_nettype none
module dupfs_top
	import dupfs_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_serial_in_chan_a,
	input wire logic i_serial_in_chan_b,
	input wire logic [NUM_IN-1:0] i_multi_in,
	input wire logic i_master_reset_n,
	input wire logic i_chip_select_n,
	input wire logic i_read_write,
	input wire logic [ADDR_W-1:0] i_register_select,
	input wire logic [DATA_W-1:0] i_host_data,
	output logic [DATA_W-1:0] o_host_data,
	output logic o_host_data_oe,
	output logic o_transfer_ack_n,
	output logic o_transfer_ack_oe,
	output logic o_serial_out_chan_a,
	output logic o_serial_out_chan_b,
	output logic [NUM_OUT-1:0] o_multi_out,
	output logic [NUM_OUT-1:0] o_multi_out_oe,
	input wire dupfs_cfg_t i_cfg,
	input wire dupfs_core_t i_core,
	input wire logic [NUM_OUT-1:0] i_gpo,
	output dupfs_pins_t o_pins,
	output logic o_device_reset,
	output logic o_rd_stb,
	output logic [ADDR_W-1:0] o_rd_addr,
	input wire logic [DATA_W-1:0] i_rd_data,
	output logic o_wr_valid,
	input wire logic i_wr_ready,
	output dupfs_wr_t o_wr
);
	logic [PIN_W-1:0] raw;
	logic [PIN_W-1:0] sync1;
	logic [PIN_W-1:0] sync2;
	logic [PIN_W-1:0] sync3;
	logic [PIN_W-1:0] filt;
	logic [NUM_IN-1:0] mi_prev;
	dupfs_host_state_t state;
	dupfs_host_state_t next_state;
	dupfs_wr_t wr_lat;
	dupfs_pins_t next_pins;
	logic [NUM_OUT-1:0] next_mo;
	logic [NUM_OUT-1:0] next_oe;
	logic buf_in_ready;

	assign raw = {i_host_data, i_register_select, i_read_write, i_chip_select_n,
		i_master_reset_n, i_multi_in, i_serial_in_chan_b, i_serial_in_chan_a};

	// A level counts only when the last two stages agree, which rejects one-cycle glitches.
	for (genvar g = 0; g < PIN_W; g++) begin : g_sync
		always_ff @(posedge i_sys_clk or posedge i_rst) begin
			if (i_rst) begin
				sync1[g] <= SYNC_RST;
				sync2[g] <= SYNC_RST;
				sync3[g] <= SYNC_RST;
				filt[g] <= SYNC_RST;
			end else begin
				sync1[g] <= raw[g];
				sync2[g] <= sync1[g];
				sync3[g] <= sync2[g];
				if (sync2[g] == sync3[g]) begin
					filt[g] <= sync3[g];
				end
			end
		end
	end

	wire pin_reset = ~filt[PIN_RST];
	wire cs_act = ~filt[PIN_CS];
	wire rw_read = filt[PIN_RW];
	wire [ADDR_W-1:0] addr_pin = filt[PIN_ADDR +: ADDR_W];
	wire [DATA_W-1:0] data_pin = filt[PIN_DATA +: DATA_W];
	wire [NUM_IN-1:0] mi = filt[PIN_MI +: NUM_IN];
	wire [NUM_IN-1:0] mi_rise = mi & ~mi_prev;
	wire [NUM_IN-1:0] mi_fall = ~mi & mi_prev;

	// Input routing towards the channel logic.
	always_comb begin
		next_pins = PINS_RST;
		if (!pin_reset) begin
			next_pins.serial_in_chan_a = filt[PIN_RXA];
			next_pins.serial_in_chan_b = filt[PIN_RXB];
			next_pins.gpi = mi;
			// With the function off the channel sees a permanent clear-to-send.
			next_pins.clear_to_send_a_n = i_cfg.cts_en_a ? mi[MI_CTS_A] : 1'b0;
			next_pins.clear_to_send_b_n = i_cfg.cts_en_b ? mi[MI_CTS_B] : 1'b0;
			next_pins.rxb_sample = i_cfg.ext_rxb && mi_rise[MI_RXB_CLK];
			next_pins.ct_clk = i_cfg.ext_ct && mi_rise[MI_RXB_CLK];
			next_pins.txa_shift = i_cfg.ext_txa && mi_fall[MI_TXA_CLK];
			next_pins.txb_shift = i_cfg.ext_txb && mi_fall[MI_TXB_CLK];
			next_pins.rxa_sample = i_cfg.ext_rxa && mi_rise[MI_RXA_CLK];
		end
	end

	// Output functions; open-drain pins drive low only, else they release.
	wire op0_val = i_cfg.rts_en_a ? i_core.request_to_send_a_n : i_gpo[0];
	wire op1_val = i_cfg.rts_en_b ? i_core.request_to_send_b_n : i_gpo[1];
	wire op2_val = (i_cfg.op2_sel == OP2_TXA_X1) ? i_core.chan_a_tx_clock_x1 :
		(i_cfg.op2_sel == OP2_TXA_X16) ? i_core.chan_a_tx_clock_x16 :
		(i_cfg.op2_sel == OP2_RXA_X1) ? i_core.chan_a_rx_clock_x1 : i_gpo[2];
	wire op3_ct = i_cfg.op3_sel == OP3_CT;
	wire op3_val = (i_cfg.op3_sel == OP3_TXB_X1) ? i_core.chan_b_tx_clock_x1 :
		(i_cfg.op3_sel == OP3_RXB_X1) ? i_core.chan_b_rx_clock_x1 : i_gpo[3];
	wire [NUM_OUT-1:0] od_sel = {i_cfg.op7_alt, i_cfg.op6_alt, i_cfg.op5_alt,
		i_cfg.op4_alt, op3_ct, 3'h0};
	wire [NUM_OUT-1:0] od_level = {i_core.chan_b_tx_hold_empty_n, i_core.chan_a_tx_hold_empty_n,
		i_core.chan_b_rx_flag_n, i_core.chan_a_rx_flag_n, i_core.ct_out, 3'h7};
	wire [NUM_OUT-1:0] pp_val = {i_gpo[7:4], op3_val, op2_val, op1_val, op0_val};

	assign next_mo = pin_reset ? MO_RST : (od_sel & {NUM_OUT{1'b0}}) | (~od_sel & pp_val);
	assign next_oe = pin_reset ? MO_OE_RST : (od_sel & ~od_level) | ~od_sel;

	// Mark is forced whenever the character path must not reach the line.
	wire mark_a = pin_reset || i_core.loop_a || !i_core.tx_en_a;
	wire mark_b = pin_reset || i_core.loop_b || !i_core.tx_en_b;

	// Host cycle sequencing.
	wire wr_pending = o_wr_valid;
	always_comb begin
		next_state = state;
		case (state)
			HS_IDLE: begin
				if (cs_act) begin
					next_state = rw_read ? HS_RD_WAIT : HS_WR_PUSH;
				end
			end
			HS_WR_PUSH: begin
				if (buf_in_ready) begin
					next_state = HS_ACK;
				end
			end
			HS_RD_WAIT: begin
				// Reads wait for buffered writes so they never overtake them.
				if (!wr_pending) begin
					next_state = HS_RD_STB;
				end
			end
			HS_RD_STB: next_state = HS_RD_CAP;
			HS_RD_CAP: next_state = HS_ACK;
			HS_ACK: begin
				if (!cs_act) begin
					next_state = HS_IDLE;
				end
			end
			default: next_state = HS_IDLE;
		endcase
		if (pin_reset) begin
			next_state = HS_IDLE;
		end
	end

	wire next_ack = next_state == HS_ACK;
	wire capture = state == HS_RD_CAP;
	wire take_req = state == HS_IDLE && next_state != HS_IDLE;
	wire next_read_drive = next_ack && (capture || o_host_data_oe);

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= HS_IDLE;
			mi_prev <= '1;
			wr_lat <= '0;
			o_pins <= PINS_RST;
			o_multi_out <= MO_RST;
			o_multi_out_oe <= MO_OE_RST;
			o_serial_out_chan_a <= 1'b1;
			o_serial_out_chan_b <= 1'b1;
			o_device_reset <= 1'b1;
			o_rd_stb <= 1'b0;
			o_rd_addr <= ADDR_RST;
			o_host_data <= HOST_DATA_RST;
			o_host_data_oe <= 1'b0;
			o_transfer_ack_n <= 1'b1;
			o_transfer_ack_oe <= 1'b0;
		end else begin
			state <= next_state;
			mi_prev <= mi;
			o_pins <= next_pins;
			o_multi_out <= next_mo;
			o_multi_out_oe <= next_oe;
			o_serial_out_chan_a <= mark_a ? 1'b1 : i_core.tx_bit_a;
			o_serial_out_chan_b <= mark_b ? 1'b1 : i_core.tx_bit_b;
			o_device_reset <= pin_reset;
			o_rd_stb <= next_state == HS_RD_STB;
			if (take_req) begin
				wr_lat <= '{addr: addr_pin, data: data_pin};
				o_rd_addr <= addr_pin;
			end
			if (capture) begin
				o_host_data <= i_rd_data;
			end
			o_host_data_oe <= next_read_drive;
			o_transfer_ack_n <= ~next_ack;
			o_transfer_ack_oe <= next_ack;
		end
	end

	// Two entries let a write complete while the core is still stalled.
	dupfs_buf #(
		.WIDTH(WR_W),
		.DEPTH(WR_DEPTH)
	) u_wr_buf (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_in_valid(state == HS_WR_PUSH),
		.o_in_ready(buf_in_ready),
		.i_in_data(wr_lat),
		.o_out_valid(o_wr_valid),
		.i_out_ready(i_wr_ready),
		.o_out_data(o_wr)
	);

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	a_rx_level_pass: assert property (!pin_reset |=>
		o_pins.serial_in_chan_a == $past(filt[PIN_RXA]))
		else $error("serial input level not passed through");
	a_rx_level_b: assert property (!pin_reset |=>
		o_pins.serial_in_chan_b == $past(filt[PIN_RXB]))
		else $error("serial input B level not passed through");
	a_tx_data_b: assert property (!mark_b |=>
		o_serial_out_chan_b == $past(i_core.tx_bit_b))
		else $error("transmit bit not forwarded on channel B");
	a_tx_data_a: assert property (!mark_a |=>
		o_serial_out_chan_a == $past(i_core.tx_bit_a))
		else $error("transmit bit not forwarded on channel A");
	a_serial_mark_a: assert property (mark_a |=> o_serial_out_chan_a)
		else $error("channel A output not held at mark");
	a_serial_mark_b: assert property (mark_b |=> o_serial_out_chan_b)
		else $error("channel B output not held at mark");
	a_cts_route_b: assert property (i_cfg.cts_en_b && !pin_reset |=>
		o_pins.clear_to_send_b_n == $past(mi[MI_CTS_B]))
		else $error("clear-to-send B not routed");
	a_cts_off_clear: assert property (!i_cfg.cts_en_a && !pin_reset |=>
		!o_pins.clear_to_send_a_n)
		else $error("clear-to-send A not clear while unused");
	a_rxb_clk_edge: assert property (o_pins.rxb_sample |->
		$past(mi_rise[MI_RXB_CLK]) && $past(i_cfg.ext_rxb))
		else $error("channel B sample without rising edge");
	a_ct_clk_edge: assert property (o_pins.ct_clk |->
		$past(mi_rise[MI_RXB_CLK]) && $past(i_cfg.ext_ct))
		else $error("counter clock without rising edge");
	a_txa_fall_edge: assert property (o_pins.txa_shift |->
		$past(mi[MI_TXA_CLK], 2) && !$past(mi[MI_TXA_CLK]))
		else $error("channel A shift without falling edge");
	a_txb_fall_edge: assert property (o_pins.txb_shift |->
		$past(mi[MI_TXB_CLK], 2) && !$past(mi[MI_TXB_CLK]))
		else $error("channel B shift without falling edge");
	a_rxa_rise_edge: assert property (i_cfg.ext_rxa && mi_rise[MI_RXA_CLK] && !pin_reset |=>
		o_pins.rxa_sample)
		else $error("channel A rising edge not signalled");
	a_rts_route_a: assert property (i_cfg.rts_en_a && !pin_reset |=>
		o_multi_out[0] == $past(i_core.request_to_send_a_n))
		else $error("request-to-send A not routed");
	a_rts_route_b: assert property (i_cfg.rts_en_b && !pin_reset |=>
		o_multi_out[1] == $past(i_core.request_to_send_b_n))
		else $error("request-to-send B not routed");
	a_op2_x16_sel: assert property (i_cfg.op2_sel == OP2_TXA_X16 && !pin_reset |=>
		o_multi_out[2] == $past(i_core.chan_a_tx_clock_x16) && o_multi_out_oe[2])
		else $error("output 2 not carrying transmit 16X clock");
	a_op3_ct_drain: assert property (op3_ct && !pin_reset |=>
		o_multi_out_oe[3] == !$past(i_core.ct_out) && !o_multi_out[3])
		else $error("output 3 counter not open drain");
	a_op3_txb_sel: assert property (i_cfg.op3_sel == OP3_TXB_X1 && !pin_reset |=>
		o_multi_out[3] == $past(i_core.chan_b_tx_clock_x1) && o_multi_out_oe[3])
		else $error("output 3 not carrying transmit 1X clock");
	a_op4_rx_flag: assert property (i_cfg.op4_alt && !i_core.chan_a_rx_flag_n && !pin_reset |=>
		o_multi_out_oe[4] && !o_multi_out[4])
		else $error("output 4 receive flag not pulled low");
	a_op5_release: assert property (i_cfg.op5_alt && i_core.chan_b_rx_flag_n && !pin_reset |=>
		!o_multi_out_oe[5])
		else $error("output 5 not released");
	a_op5_rx_flag: assert property (i_cfg.op5_alt && !i_core.chan_b_rx_flag_n && !pin_reset |=>
		o_multi_out_oe[5] && !o_multi_out[5])
		else $error("output 5 receive flag not pulled low");
	a_op7_tx_empty: assert property (i_cfg.op7_alt && !pin_reset |=>
		o_multi_out_oe[7] == !$past(i_core.chan_b_tx_hold_empty_n))
		else $error("output 7 transmit flag wrong");
	a_op6_tx_empty: assert property (i_cfg.op6_alt && !pin_reset |=>
		o_multi_out_oe[6] == !$past(i_core.chan_a_tx_hold_empty_n) && !o_multi_out[6])
		else $error("output 6 transmit flag wrong");
	a_rd_addr_take: assert property (take_req |=> o_rd_addr == $past(addr_pin))
		else $error("register select not captured");
	a_rd_stb_pulse: assert property (o_rd_stb |=> !o_rd_stb)
		else $error("read strobe longer than one cycle");
	a_reset_outputs: assert property (pin_reset |=>
		o_transfer_ack_n && !o_host_data_oe && o_multi_out == MO_RST && o_device_reset)
		else $error("reset pin did not initialise outputs");
	a_write_ack: assert property (state == HS_WR_PUSH && buf_in_ready && !pin_reset |=>
		!o_transfer_ack_n && o_transfer_ack_oe && !o_host_data_oe)
		else $error("write not acknowledged");
	a_read_ack: assert property ($rose(o_rd_stb) && !pin_reset ##1 !pin_reset |=>
		!o_transfer_ack_n && o_host_data_oe)
		else $error("read not acknowledged two cycles after strobe");
	a_wr_stall_wait: assert property (state == HS_WR_PUSH && !buf_in_ready |=>
		o_transfer_ack_n)
		else $error("write acknowledged while buffer full");
	a_ack_release: assert property (state == HS_ACK && !cs_act |=>
		o_transfer_ack_n && !o_transfer_ack_oe && !o_host_data_oe)
		else $error("acknowledge not released after chip select");
	a_gpo_default: assert property (!i_cfg.rts_en_b && !pin_reset |=>
		o_multi_out[1] == $past(i_gpo[1]) && o_multi_out_oe[1])
		else $error("output 1 does not follow general bit");
endmodule // dupfs_top
`default_nettype wire

// ### dupfs_core_model.sv
// Behavioural model of the channel core that sits behind the host side of the block.
`timescale 1ns/1ps
`default_nettype none
module dupfs_core_model
	import dupfs_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_stall,
	input wire logic i_rd_stb,
	input wire logic [ADDR_W-1:0] i_rd_addr,
	output logic [DATA_W-1:0] o_rd_data,
	output logic o_wr_ready
);
	// Read data is only promised for the cycle after the strobe, so it is scrambled after that.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rd_data <= 8'h00;
		end else if (i_rd_stb) begin
			o_rd_data <= {4'h5, i_rd_addr};
		end else begin
			o_rd_data <= ~o_rd_data;
		end
	end
	assign o_wr_ready = ~i_stall;
endmodule // dupfs_core_model
`default_nettype wire

// ### tb_dual_uart_pin_function_select.sv
// Self-checking testbench of the pin function select block.
`timescale 1ns/1ps
`default_nettype none
module tb_dual_uart_pin_function_select
	import dupfs_pkg::*;
;
	logic i_sys_clk, i_rst, sin_a, sin_b, mrst_n, cs_n, rw, stall, hold_stall;
	logic [5:0] mi;
	logic [3:0] rsel;
	logic [7:0] hd, gpo, hq, rd_data, mo, moe;
	logic hq_oe, ack_n, ack_oe, so_a, so_b, dev_rst, rd_stb, wr_valid, wr_ready;
	logic [3:0] rd_addr;
	dupfs_cfg_t cfg;
	dupfs_core_t core;
	dupfs_pins_t pins;
	dupfs_wr_t wr;
	dupfs_wr_t wq[$];
	logic [31:0] seed = 32'h0069;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	int last_wait;
	int pcnt [5] = '{0, 0, 0, 0, 0};

	dupfs_top dupfs_top_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_serial_in_chan_a(sin_a), .i_serial_in_chan_b(sin_b), .i_multi_in(mi),
		.i_master_reset_n(mrst_n), .i_chip_select_n(cs_n), .i_read_write(rw),
		.i_register_select(rsel), .i_host_data(hd), .o_host_data(hq), .o_host_data_oe(hq_oe),
		.o_transfer_ack_n(ack_n), .o_transfer_ack_oe(ack_oe), .o_serial_out_chan_a(so_a),
		.o_serial_out_chan_b(so_b), .o_multi_out(mo), .o_multi_out_oe(moe), .i_cfg(cfg),
		.i_core(core), .i_gpo(gpo), .o_pins(pins), .o_device_reset(dev_rst),
		.o_rd_stb(rd_stb), .o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_wr_valid(wr_valid),
		.i_wr_ready(wr_ready), .o_wr(wr));
	dupfs_core_model dupfs_core_model_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_stall(stall), .i_rd_stb(rd_stb), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
		.o_wr_ready(wr_ready));

	initial begin
		i_sys_clk = 1'b0;
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Open-drain functions never drive high, they only release the pin.
	function automatic logic [15:0] exp_out(dupfs_cfg_t c, dupfs_core_t k, logic [7:0] g);
		logic [7:0] v, od;
		v = g;
		od = 8'h00;
		if (c.rts_en_a) v[0] = k.request_to_send_a_n;
		if (c.rts_en_b) v[1] = k.request_to_send_b_n;
		case (c.op2_sel)
			OP2_TXA_X1: v[2] = k.chan_a_tx_clock_x1;
			OP2_TXA_X16: v[2] = k.chan_a_tx_clock_x16;
			OP2_RXA_X1: v[2] = k.chan_a_rx_clock_x1;
			default: ;
		endcase
		case (c.op3_sel)
			OP3_CT: {v[3], od[3]} = {k.ct_out, 1'b1};
			OP3_TXB_X1: v[3] = k.chan_b_tx_clock_x1;
			OP3_RXB_X1: v[3] = k.chan_b_rx_clock_x1;
			default: ;
		endcase
		if (c.op4_alt) {v[4], od[4]} = {k.chan_a_rx_flag_n, 1'b1};
		if (c.op5_alt) {v[5], od[5]} = {k.chan_b_rx_flag_n, 1'b1};
		if (c.op6_alt) {v[6], od[6]} = {k.chan_a_tx_hold_empty_n, 1'b1};
		if (c.op7_alt) {v[7], od[7]} = {k.chan_b_tx_hold_empty_n, 1'b1};
		return {v & ~od, ~od | ~v};
	endfunction

	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Address, direction and data settle long before chip select falls.
	task automatic host(input logic r, input logic [3:0] a, input logic [7:0] d);
		int t;
		rw <= r;
		rsel <= a;
		hd <= d;
		if (!r) wq.push_back({a, d});
		repeat (5) @(posedge i_sys_clk);
		cs_n <= 1'b0;
		t = 0;
		do begin
			@(negedge i_sys_clk);
			t++;
		end while (!(ack_n === 1'b0 && ack_oe === 1'b1) && t < 300);
		last_wait = t;
		check("ack_wait", 16'(t < 300), 16'h1);
		if (r) begin
			check("read_data", 16'({hq_oe, hq}), 16'({1'b1, 4'h5, a}));
			check("wr_drained", 16'(wq.size()), 16'h0);
		end
		@(posedge i_sys_clk);
		cs_n <= 1'b1;
		repeat (8) @(posedge i_sys_clk);
		check("ack_release", 16'({ack_oe, hq_oe}), 16'h0);
	endtask

	always @(posedge i_sys_clk) begin
		cyc++;
		stall <= hold_stall | (cyc[0] ^ cyc[2]);
		for (int k = 0; k < 5; k++) if (pins[k] === 1'b1) pcnt[k]++;
		if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
			check("wr_word", 16'(wr), 16'((wq.size() > 0) ? wq.pop_front() : ~wr));
		end
		if (cyc == 20000) begin
			n_mismatch++;
			final_report();
		end
	end

	initial begin
		logic [31:0] r;
		dupfs_cfg_t c;
		dupfs_core_t k;
		int base [5];
		logic [4:0] rise_m [6] = '{5'h0, 5'h0, 5'h18, 5'h0, 5'h02, 5'h0};
		logic [4:0] fall_m [6] = '{5'h0, 5'h0, 5'h0, 5'h04, 5'h0, 5'h01};
		// The remote line idles at mark in every scenario except the random output loop.
		{sin_a, sin_b} = 2'h3;
		{i_rst, mrst_n, cs_n, rw, stall, hold_stall} = 6'h3e;
		{mi, rsel, hd, gpo, cfg, core} = '0;
		repeat (8) @(posedge i_sys_clk);
		check("reset_outs", {mo, moe}, 16'hffff);
		check("reset_misc", 16'({so_a, so_b, ack_oe, hq_oe, dev_rst}), 16'h19);
		i_rst <= 1'b0;
		core <= dupfs_core_t'(18'h08000);
		repeat (4) @(posedge i_sys_clk);
		check("serial_a_space", 16'(so_a), 16'h0);
		mrst_n <= 1'b0;
		repeat (8) @(posedge i_sys_clk);
		check("mreset_outs", 16'({so_a, dev_rst, mo}), 16'({2'h3, 8'hff}));
		mrst_n <= 1'b1;
		repeat (8) @(posedge i_sys_clk);
		for (int it = 0; it < 48; it++) begin
			r = xs();
			c = r[$bits(dupfs_cfg_t)-1:0];
			c.op2_sel = it[1:0];
			c.op3_sel = it[3:2];
			cfg <= c;
			r = xs();
			k = r[$bits(dupfs_core_t)-1:0];
			core <= k;
			gpo <= r[31:24];
			{mi, sin_a, sin_b} <= 8'(xs() >> 24);
			repeat (7) @(posedge i_sys_clk);
			check("multi_out", {mo, moe}, exp_out(c, k, gpo));
			check("serial_out", 16'({so_a, so_b}),
				16'({~k.tx_en_a | k.loop_a ? 1'b1 : k.tx_bit_a,
				~k.tx_en_b | k.loop_b ? 1'b1 : k.tx_bit_b}));
			check("rx_levels", 16'({pins.serial_in_chan_a, pins.serial_in_chan_b}),
				16'({sin_a, sin_b}));
			check("cts_gpi", 16'({pins.clear_to_send_a_n, pins.clear_to_send_b_n, pins.gpi}),
				16'({c.cts_en_a & mi[0], c.cts_en_b & mi[1], mi}));
		end
		{sin_a, sin_b} <= 2'h3;
		for (int en = 0; en < 2; en++) begin
			c = '0;
			c[4:0] = {5{en[0]}};
			cfg <= c;
			mi <= 6'h0;
			repeat (8) @(posedge i_sys_clk);
			for (int p = 2; p < 6; p++) begin
				for (int e = 1; e >= 0; e--) begin
					base = pcnt;
					mi[p] <= e[0];
					repeat (10) @(posedge i_sys_clk);
					for (int q = 0; q < 5; q++) begin
						check("pulse", 16'(pcnt[q] - base[q]),
							16'((e ? rise_m[p][q] : fall_m[p][q]) & en[0]));
					end
				end
			end
		end
		hold_stall = 1'b1;
		host(1'b0, 4'h3, 8'ha5);
		host(1'b0, 4'hc, 8'h5a);
		fork
			host(1'b0, 4'hf, 8'h01);
			begin
				repeat (60) @(posedge i_sys_clk);
				hold_stall = 1'b0;
			end
		join
		check("full_stall", 16'(last_wait > 40), 16'h1);
		host(1'b1, 4'h7, 8'h00);
		for (int it = 0; it < 16; it++) begin
			r = xs();
			host(r[0], r[7:4], r[15:8]);
		end
		final_report();
	end
endmodule // tb_dual_uart_pin_function_select
`default_nettype wire
